// ==== port_status_pkg.sv ====
package port_status_pkg;

  // configuration byte offsets as printed
  localparam logic [11:0] LINK_STATE_REPORT_OFS   = 12'h0A2;
  localparam logic [11:0] SLOT_FEATURE_REPORT_OFS = 12'h0A4;
  // the link status half-word shares its dword with link control
  localparam int          LINK_STATE_LANE_SHIFT   = 16;

  // link_state_report fields
  localparam int LINK_ACTIVE_BIT     = 13;
  localparam int SLOT_CLOCK_BIT      = 12;
  localparam int LINK_TRAINING_BIT   = 11;
  localparam int NEG_WIDTH_MSB       = 9;
  localparam int NEG_WIDTH_LSB       = 4;
  localparam int NEG_WIDTH_W         = 6;
  localparam logic SLOT_CLOCK_RESET  = 1'b1;

  // slot_feature_report fields
  localparam int SLOT_NUMBER_MSB     = 31;
  localparam int SLOT_NUMBER_LSB     = 19;
  localparam int CMD_CPL_NOT_CAP_BIT = 18;
  localparam int INTERLOCK_BIT       = 17;
  localparam int HOT_PLUG_CAP_BIT    = 6;
  localparam int SURPRISE_BIT        = 5;
  localparam int PWR_IND_BIT         = 4;
  localparam int ATTN_IND_BIT        = 3;
  localparam int LATCH_SENSOR_BIT    = 2;
  localparam int PWR_CTRL_BIT        = 1;
  localparam int ATTN_BUTTON_BIT     = 0;
  localparam logic CMD_CPL_NOT_CAP_VAL = 1'b0;
  localparam logic [31:0] SLOT_FEATURE_RESET   = 32'h0000_0000;
  localparam logic [31:0] SLOT_FEATURE_WO_MASK = 32'hFFFA_007F;

  // lane counts allowed on the chipset-link port
  localparam logic [5:0] LANES_X1 = 6'h01;
  localparam logic [5:0] LANES_X2 = 6'h02;
  localparam logic [5:0] LANES_X4 = 6'h04;

endpackage : port_status_pkg

// ==== write_once_field.sv ====
`timescale 1ns/1ps
`default_nettype none

module write_once_field #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] mask_i,
  input  wire logic [W-1:0] wdata_i,
  output logic      [W-1:0] val_o
);

  typedef struct packed {
    logic [W-1:0] val;
    logic         locked;
  } wo_state_s;

  wo_state_s s_q;
  wo_state_s s_d;

  always_comb
  begin
    s_d = s_q;
    // only the first write after reset lands; later ones are dropped
    if (wr_i && !s_q.locked)
    begin
      s_d.val    = (s_q.val & ~mask_i) | (wdata_i & mask_i);
      s_d.locked = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      s_q.val    <= RST;
      s_q.locked <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign val_o = s_q.val;

endmodule : write_once_field

`default_nettype wire

// ==== port_status_regs.sv ====
// What this block does
// - training bit is 1 in recovery/configuration or while a retrain is pending
// - hardware clears the training bit on leaving recovery/configuration, no write needed
// - negotiated width is read-only, bits 9:4, lane count in binary
// - chipset-link port reports only one, two or four lanes
// - slot clock configuration is write-once and resets to 1
// - physical slot number sits at bits 31:19, resets zero, write-once
// - command-completion-not-capable bit is read-only zero
// - interlock-present bit is write-once, flags chassis interlock
// - hot-plug capable bit is write-once, firmware matches expander enable
// - with surprise bit on a hot-plug slot, link loss is no surprise-down error
// - power indicator present bit is write-once
// - attention indicator present bit is write-once
// - retention-latch sensor present bit is write-once
// - power controller present bit is write-once
// - attention button present bit is write-once, resets zero
`timescale 1ns/1ps
`default_nettype none

module port_status_regs
  import port_status_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // configuration access: byte address, dword aligned, with byte enables
  input  wire logic [11:0] cfg_addr_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_rvalid_o,
  // link state from the port core
  input  wire logic        ltssm_recovery_i,
  input  wire logic        ltssm_config_i,
  input  wire logic        retrain_req_i,
  input  wire logic        dl_active_i,
  input  wire logic [5:0]  lane_count_i,
  input  wire logic        chipset_link_port_i,
  // results
  output logic             link_training_o,
  output logic             link_active_o,
  output logic             hot_plug_capable_o,
  output logic             surprise_down_err_o
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        rvalid;
    logic        retrain_pending;
    logic        training;
    logic        dl_active;
    logic [5:0]  width;
    logic        hp_capable;
    logic        sd_err;
  } port_state_s;

  port_state_s s_q;
  port_state_s s_d;

  logic [31:0] slot_feature;
  logic [SLOT_NUMBER_MSB:SLOT_NUMBER_LSB] slot_number;
  logic        interlock;
  logic        hp_capable;
  logic        surprise;
  logic        pwr_ind;
  logic        attn_ind;
  logic        latch_sensor;
  logic        pwr_ctrl;
  logic        attn_button;
  logic        wr_slot;
  logic        slot_clock;
  logic [31:0] be_mask;
  logic        hit_link;
  logic        hit_slot;
  logic [15:0] link_word;
  logic [31:0] slot_word;
  logic        in_rc;

  function automatic logic [31:0] lanes_of(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lanes_of

  function automatic logic [5:0] chipset_width(input logic [5:0] lanes);
    logic [5:0] w;
    if (lanes >= LANES_X4)
    begin
      w = LANES_X4;
    end
    else if (lanes >= LANES_X2)
    begin
      w = LANES_X2;
    end
    else
    begin
      w = LANES_X1;
    end
    return w;
  endfunction : chipset_width

  assign be_mask  = lanes_of(cfg_be_i);
  assign hit_link = cfg_addr_i[11:2] == LINK_STATE_REPORT_OFS[11:2];
  assign hit_slot = cfg_addr_i[11:2] == SLOT_FEATURE_REPORT_OFS[11:2];
  assign in_rc    = ltssm_recovery_i | ltssm_config_i;
  assign wr_slot  = cfg_wr_i && hit_slot;

  // slot clock configuration lives in the upper half of the shared dword
  write_once_field #(
    .W   (1),
    .RST (SLOT_CLOCK_RESET)
  ) u_slot_clock (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (cfg_wr_i && hit_link
                && be_mask[SLOT_CLOCK_BIT + LINK_STATE_LANE_SHIFT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[SLOT_CLOCK_BIT + LINK_STATE_LANE_SHIFT]),
    .val_o     (slot_clock)
  );

  // each field locks on its own; a write reaching any byte of the number locks all of it
  write_once_field #(
    .W   (SLOT_NUMBER_MSB - SLOT_NUMBER_LSB + 1),
    .RST (SLOT_FEATURE_RESET[SLOT_NUMBER_MSB:SLOT_NUMBER_LSB])
  ) u_slot_number (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && |be_mask[SLOT_NUMBER_MSB:SLOT_NUMBER_LSB]),
    .mask_i    (be_mask[SLOT_NUMBER_MSB:SLOT_NUMBER_LSB]),
    .wdata_i   (cfg_wdata_i[SLOT_NUMBER_MSB:SLOT_NUMBER_LSB]),
    .val_o     (slot_number)
  );

  write_once_field #(.W(1), .RST(SLOT_FEATURE_RESET[INTERLOCK_BIT])) u_interlock (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && be_mask[INTERLOCK_BIT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[INTERLOCK_BIT]),
    .val_o     (interlock)
  );

  write_once_field #(.W(1), .RST(SLOT_FEATURE_RESET[HOT_PLUG_CAP_BIT])) u_hp_capable (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && be_mask[HOT_PLUG_CAP_BIT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[HOT_PLUG_CAP_BIT]),
    .val_o     (hp_capable)
  );

  write_once_field #(.W(1), .RST(SLOT_FEATURE_RESET[SURPRISE_BIT])) u_surprise (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && be_mask[SURPRISE_BIT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[SURPRISE_BIT]),
    .val_o     (surprise)
  );

  write_once_field #(.W(1), .RST(SLOT_FEATURE_RESET[PWR_IND_BIT])) u_pwr_ind (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && be_mask[PWR_IND_BIT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[PWR_IND_BIT]),
    .val_o     (pwr_ind)
  );

  write_once_field #(.W(1), .RST(SLOT_FEATURE_RESET[ATTN_IND_BIT])) u_attn_ind (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && be_mask[ATTN_IND_BIT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[ATTN_IND_BIT]),
    .val_o     (attn_ind)
  );

  write_once_field #(.W(1), .RST(SLOT_FEATURE_RESET[LATCH_SENSOR_BIT])) u_latch_sensor (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && be_mask[LATCH_SENSOR_BIT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[LATCH_SENSOR_BIT]),
    .val_o     (latch_sensor)
  );

  write_once_field #(.W(1), .RST(SLOT_FEATURE_RESET[PWR_CTRL_BIT])) u_pwr_ctrl (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && be_mask[PWR_CTRL_BIT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[PWR_CTRL_BIT]),
    .val_o     (pwr_ctrl)
  );

  write_once_field #(.W(1), .RST(SLOT_FEATURE_RESET[ATTN_BUTTON_BIT])) u_attn_button (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_slot && be_mask[ATTN_BUTTON_BIT]),
    .mask_i    (1'b1),
    .wdata_i   (cfg_wdata_i[ATTN_BUTTON_BIT]),
    .val_o     (attn_button)
  );

  always_comb
  begin
    link_word = '0;
    link_word[LINK_ACTIVE_BIT]               = s_q.dl_active;
    link_word[SLOT_CLOCK_BIT]                = slot_clock;
    link_word[LINK_TRAINING_BIT]             = s_q.training;
    link_word[NEG_WIDTH_MSB:NEG_WIDTH_LSB]   = s_q.width;

    // fixed and reserved bits keep their reset value
    slot_feature = SLOT_FEATURE_RESET;
    slot_feature[SLOT_NUMBER_MSB:SLOT_NUMBER_LSB] = slot_number;
    slot_feature[INTERLOCK_BIT]    = interlock;
    slot_feature[HOT_PLUG_CAP_BIT] = hp_capable;
    slot_feature[SURPRISE_BIT]     = surprise;
    slot_feature[PWR_IND_BIT]      = pwr_ind;
    slot_feature[ATTN_IND_BIT]     = attn_ind;
    slot_feature[LATCH_SENSOR_BIT] = latch_sensor;
    slot_feature[PWR_CTRL_BIT]     = pwr_ctrl;
    slot_feature[ATTN_BUTTON_BIT]  = attn_button;
    slot_word = slot_feature & SLOT_FEATURE_WO_MASK;
    // the port does signal command completion, so this stays zero
    slot_word[CMD_CPL_NOT_CAP_BIT] = CMD_CPL_NOT_CAP_VAL;
  end

  always_comb
  begin
    s_d = s_q;

    // a retrain request waits until the state machine actually leaves L0
    if (retrain_req_i)
    begin
      s_d.retrain_pending = 1'b1;
    end
    else if (in_rc)
    begin
      s_d.retrain_pending = 1'b0;
    end
    // cleared purely by state; no software write involved
    s_d.training = in_rc | s_q.retrain_pending | retrain_req_i;

    s_d.dl_active = dl_active_i;

    // width is sampled always; only meaningful while link is active
    if (chipset_link_port_i)
    begin
      s_d.width = chipset_width(lane_count_i);
    end
    else
    begin
      s_d.width = lane_count_i;
    end

    s_d.hp_capable = slot_feature[HOT_PLUG_CAP_BIT];

    // a drop of link active is an error unless the slot allows surprise removal
    s_d.sd_err = s_q.dl_active && !dl_active_i
                 && !(slot_feature[HOT_PLUG_CAP_BIT]
                      && slot_feature[SURPRISE_BIT]);

    s_d.rvalid = cfg_rd_i;
    if (cfg_rd_i)
    begin
      if (hit_link)
      begin
        s_d.rdata = {link_word, 16'h0000};
      end
      else if (hit_slot)
      begin
        s_d.rdata = slot_word;
      end
      else
      begin
        // unmapped offsets read as zero
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata_o         = s_q.rdata;
  assign cfg_rvalid_o        = s_q.rvalid;
  assign link_training_o     = s_q.training;
  assign link_active_o       = s_q.dl_active;
  assign hot_plug_capable_o  = s_q.hp_capable;
  assign surprise_down_err_o = s_q.sd_err;

endmodule : port_status_regs

`default_nettype wire

// ==== link_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// far end of the link: trains through recovery then configuration, then holds the link up
module link_partner (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic go_i,
  input  wire logic drop_i,
  output logic      rec_o,
  output logic      cfg_o,
  output logic      up_o
);
  logic [2:0] n_q;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || drop_i)
    begin
      n_q  <= 3'h0;
      up_o <= 1'b0;
    end
    else if (go_i)
      n_q <= 3'h5;
    else if (n_q != 3'h0)
    begin
      n_q  <= n_q - 3'h1;
      up_o <= up_o || n_q == 3'h1;
    end
  end
  assign rec_o = n_q > 3'h2;
  assign cfg_o = n_q == 3'h1 || n_q == 3'h2;
endmodule : link_partner
`default_nettype wire

// ==== port_status_regs_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_status_regs_props (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic        cfg_rd_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_rvalid_o,
  input wire logic        ltssm_recovery_i,
  input wire logic        ltssm_config_i,
  input wire logic        retrain_req_i,
  input wire logic        dl_active_i,
  input wire logic        chipset_link_port_i,
  input wire logic        link_training_o,
  input wire logic        link_active_o,
  input wire logic        hot_plug_capable_o,
  input wire logic        surprise_down_err_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [9:0] dw_q;
  always_ff @(posedge ref_clk_i)
    dw_q <= cfg_addr_i[11:2];
  // a retrain in the same cycle leaves a request pending, so it keeps the bit up
  sequence s_busy;
    (ltssm_recovery_i || ltssm_config_i) && !retrain_req_i;
  endsequence
  sequence s_left;
    s_busy ##1 !(ltssm_recovery_i || ltssm_config_i || retrain_req_i);
  endsequence
  chk_rd_answer: assert property (cfg_rd_i |=> cfg_rvalid_o) else $error("no read answer");
  chk_rv_cause: assert property (cfg_rvalid_o |-> $past(cfg_rd_i)) else $error("stray answer");
  chk_train_set: assert property ((ltssm_recovery_i || ltssm_config_i || retrain_req_i)
    |=> link_training_o) else $error("training bit low");
  chk_train_clear: assert property (s_left |=> !link_training_o)
    else $error("training bit stuck");
  chk_active_up: assert property (dl_active_i |=> link_active_o)
    else $error("active bit low");
  chk_active_down: assert property (!dl_active_i |=> !link_active_o)
    else $error("active bit high");
  chk_width_clamp: assert property (cfg_rvalid_o && dw_q == 10'h028 &&
    $past(chipset_link_port_i, 2) |-> cfg_rdata_o[25:20] inside {6'h01, 6'h02, 6'h04})
    else $error("width not 1 2 4");
  chk_cpl_zero: assert property (cfg_rvalid_o && dw_q == 10'h029 |-> !cfg_rdata_o[18])
    else $error("cmd cpl bit set");
  chk_sdown_err: assert property ($fell(dl_active_i) && !hot_plug_capable_o
    |=> surprise_down_err_o) else $error("missing down error");
  chk_err_cause: assert property (surprise_down_err_o
    |-> !$past(dl_active_i) && $past(dl_active_i, 2)) else $error("stray down error");
endmodule : port_status_regs_props
bind port_status_regs port_status_regs_props i_props (.ref_clk_i, .rst_i, .cfg_addr_i,
  .cfg_rd_i, .cfg_rdata_o, .cfg_rvalid_o, .ltssm_recovery_i, .ltssm_config_i,
  .retrain_req_i, .dl_active_i, .chipset_link_port_i, .link_training_o, .link_active_o,
  .hot_plug_capable_o, .surprise_down_err_o);
`default_nettype wire

// ==== port_status_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_status_regs_tb;
  logic        clk, rst, wr, rd, retrain, chip, go, drop, rvalid, rec, cfg, up, train, act;
  logic        hpc, err;
  logic [11:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, d, n;
  logic [5:0]  lanes;
  int          fails, total_checks;
  logic [12:0] rows [8] = '{{7'h01, 6'h01}, {7'h02, 6'h02}, {7'h08, 6'h08}, {7'h10, 6'h10},
    {7'h40, 6'h01}, {7'h43, 6'h02}, {7'h48, 6'h04}, {7'h41, 6'h01}};
  port_status_regs i_dut (.ref_clk_i(clk), .rst_i(rst), .cfg_addr_i(addr), .cfg_wr_i(wr),
    .cfg_rd_i(rd), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rvalid), .ltssm_recovery_i(rec), .ltssm_config_i(cfg),
    .retrain_req_i(retrain), .dl_active_i(up), .lane_count_i(lanes),
    .chipset_link_port_i(chip), .link_training_o(train), .link_active_o(act),
    .hot_plug_capable_o(hpc), .surprise_down_err_o(err));
  link_partner i_partner (.ref_clk_i(clk), .rst_i(rst), .go_i(go), .drop_i(drop),
    .rec_o(rec), .cfg_o(cfg), .up_o(up));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rdw(input logic [11:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rvalid, 1'b1);
    d = rdata;
  endtask : rdw
  task automatic wrw(input logic [11:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    be <= b;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrw
  // drop or train the link, then count error pulses while it settles
  task automatic link(input logic dn);
    @(posedge clk);
    drop <= dn;
    go <= !dn;
    @(posedge clk);
    drop <= 1'b0;
    go <= 1'b0;
    n = 0;
    repeat (10)
    begin
      tick(1);
      n += err;
    end
  endtask : link
  task automatic summarize;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #200us;
    fails++;
    summarize();
  end
  initial
  begin
    {rst, wr, rd, retrain, chip, go, drop, addr, be, wdata} = '0;
    rst = 1'b1;
    lanes = 6'h01;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdw(12'h0A0);
    chk(d[28:27], 2'b10);
    rdw(12'h0A4);
    chk(d, 32'h0);
    rdw(12'h100);
    chk(d, 32'h0);
    link(1'b0);
    chk(act, 1'b1);
    foreach (rows[i])
    begin
      @(posedge clk);
      {chip, lanes} <= rows[i][12:6];
      tick(2);
      rdw(12'h0A0);
      chk(d[25:20], rows[i][5:0]);
    end
    @(posedge clk);
    retrain <= 1'b1;
    @(posedge clk);
    retrain <= 1'b0;
    tick(3);
    chk(train, 1'b1);
    link(1'b0);
    chk(train, 1'b0);
    link(1'b1);
    chk(n, 1);
    link(1'b0);
    wrw(12'h0A4, 4'hF, 32'hFFFF_FFFF);
    wrw(12'h0A4, 4'hF, 32'h0);
    wrw(12'h0A0, 4'h8, 32'h0);
    wrw(12'h0A0, 4'h8, 32'hFFFF_FFFF);
    rdw(12'h0A4);
    chk(d, 32'hFFFA_007F);
    chk(hpc, 1'b1);
    rdw(12'h0A0);
    chk(d[28], 1'b0);
    link(1'b1);
    chk(n, 0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdw(12'h0A4);
    chk(d, 32'h0);
    // a byte-0 write locks only the byte-0 fields; the slot number stays open
    wrw(12'h0A4, 4'h1, 32'h0000_0001);
    wrw(12'h0A4, 4'hF, 32'h0008_0000);
    rdw(12'h0A4);
    chk(d, 32'h0008_0001);
    summarize();
  end
endmodule : port_status_regs_tb
`default_nettype wire
